// ==== rtl/ext_bus_pkg.sv ====
package ext_bus_pkg;
  // Widths of the bus and of the program address.
  localparam int ADDR_W = 21;
  localparam int PC_W = 21;
  // Address width select encodings.
  localparam logic [1:0] AW_20 = 2'h0;
  localparam logic [1:0] AW_16 = 2'h1;
  localparam logic [1:0] AW_12 = 2'h2;
  localparam logic [1:0] AW_INTERNAL = 2'h3;
  // Write mode select encodings.
  localparam logic [1:0] WM_BYTE_WRITE = 2'h0;
  localparam logic [1:0] WM_BYTE_SELECT = 2'h1;
  // Bus control register layout.
  localparam int BCR_DIS_POS = 7;
  localparam int BCR_WAIT_POS = 4;
  localparam int BCR_WM_POS = 0;
  localparam logic [7:0] BCR_RESET = 8'h00;
  localparam logic [7:0] BCR_MASK = 8'hB3;
  // Pull-up enable positions inside the port G register.
  localparam int PU_D_POS = 7;
  localparam int PU_E_POS = 6;
  localparam int PU_J_POS = 5;
  localparam logic [2:0] PU_RESET = 3'h0;
  // Default size of on-chip program memory in bytes.
  localparam logic [20:0] ONCHIP_SIZE_DEFAULT = 21'h020000;
  // Bus cycle phases.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_DATA = 3'h3,
    ST_WAIT = 3'h2
  } phase_type;
  // Inverse decode of the delay count field.
  function automatic logic [1:0] wait_cycles(input logic [1:0] field);
    wait_cycles = 2'h3 - field;
  endfunction
endpackage

// ==== rtl/ext_bus_addr_map.sv ====
module ext_bus_addr_map
  import ext_bus_pkg::*;
(
  // Address source and shift control.
  input wire logic [PC_W-1:0] pc_in,
  input wire logic shift_in,
  input wire logic [20:0] onchip_size_in,
  // Address seen by the bus.
  output logic [ADDR_W-1:0] bus_addr_out
);
  // Either the raw program counter or the counter offset down by on-chip size.
  always_comb begin
    if (shift_in) begin
      bus_addr_out = pc_in - onchip_size_in;
    end else begin
      bus_addr_out = pc_in;
    end
  end
endmodule

// ==== rtl/ext_bus_pin_owner.sv ====
module ext_bus_pin_owner
  import ext_bus_pkg::*;
(
  // Mode inputs.
  input wire logic [1:0] address_width_select_in,
  input wire logic bus_active_in,
  // Which pin groups belong to the bus.
  output logic own_low_out,
  output logic [7:0] own_mid_out,
  output logic own_high_out
);
  // The bus owns only the pins of the configured address width.
  always_comb begin
    own_low_out = bus_active_in && (address_width_select_in != AW_INTERNAL);
    own_mid_out = 8'h00;
    own_high_out = 1'b0;
    case (address_width_select_in)
      AW_20: begin
        own_mid_out = {8{bus_active_in}};
        own_high_out = bus_active_in;
      end
      AW_16: begin
        own_mid_out = {8{bus_active_in}};
      end
      AW_12: begin
        own_mid_out = {4'h0, {4{bus_active_in}}};
      end
      default: begin
        own_mid_out = 8'h00;
      end
    endcase
  end
endmodule

// ==== rtl/ext_bus_port.sv ====
// What this block does
// - Unshifted bus address equals the program counter.
// - Shift subtracts on-chip size from addresses.
// - Byte address line is the 21st address bit.
// - 21-bit addressing only in 8-bit, byte select.
// - Multiplex lines follow data and address width.
// - Table operations get zero to three waits.
// - Delay count field decodes inversely.
// - Port G top bits enable bus pull-ups.
// - Every reset clears all bus pull-ups.
// - Internal-only mode keeps bus off, register locked.
// - External access takes the pins unless internal-only.
// - Internal access: disable bit picks ports.
// - Disable from external code waits for internal.
// - Idle bus: AD lines tri-state, A19:A16 still driven, strobes high, latch low.
// - Only configured-width pins go idle.
// - Bus overrides every other pin peripheral.
// - Write mode field chooses 16-bit write scheme.
// - Field: 1x word, 01 select, 00 byte.
// - Latch strobe with address, then read enable.
// - Chip select low per access, high in sleep.
// - Byte write: latch on both halves, one strobe.
module ext_bus_port
  import ext_bus_pkg::*;
#(
  parameter logic [20:0] ONCHIP_SIZE = ONCHIP_SIZE_DEFAULT
)(
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic reset_in,
  // Configuration straps.
  input wire logic [1:0] address_width_select_in,
  input wire logic data_width_16_in,
  input wire logic address_shift_enable_in,
  input wire logic delay_insert_enable_in,
  input wire logic sleep_in,
  // Bus control register and port G write ports from the core.
  input wire logic bcr_write_in,
  input wire logic [7:0] bcr_wdata_in,
  input wire logic port_g_write_in,
  input wire logic [7:0] port_g_wdata_in,
  // Core access request.
  input wire logic access_req_in,
  input wire logic access_write_in,
  input wire logic access_external_in,
  input wire logic [PC_W-1:0] program_counter_in,
  input wire logic [7:0] table_data_latch_in,
  // Core answer.
  output logic access_done_out,
  output logic [15:0] read_data_out,
  output logic [7:0] bus_control_register_out,
  // Multiplexed address/data pins, enable low drives.
  input wire logic [15:0] ad_pin_in,
  output logic [15:0] ad_out,
  output logic [15:0] ad_oe_n_out,
  output logic [3:0] a_high_out,
  output logic [3:0] a_high_oe_n_out,
  // Control pins.
  output logic latch_strobe_out,
  output logic read_enable_n_out,
  output logic lower_write_strobe_n_out,
  output logic upper_write_strobe_n_out,
  output logic byte_address_lsb_out,
  output logic chip_select_n_out,
  output logic lower_byte_enable_n_out,
  output logic upper_byte_enable_n_out,
  output logic control_oe_n_out,
  // Pull-up enables for the three bus ports.
  output logic port_d_pullup_enable_out,
  output logic port_e_pullup_enable_out,
  output logic port_j_pullup_enable_out,
  // Pin ownership toward other peripherals.
  output logic bus_owns_pins_out
);
  // Register state.
  logic [7:0] bcr_reg; // Bus control register.
  logic [2:0] pullup_reg; // Pull-up enables.
  logic [15:0] ad_sync1_reg; // First synchroniser stage.
  logic [15:0] ad_sync2_reg; // Second synchroniser stage.
  logic ext_exec_reg; // Set while running from external memory.
  logic pins_bus_reg; // Pins are in bus function.
  phase_type phase_reg; // Bus cycle phase.
  logic [1:0] wait_reg; // Remaining wait cycles.
  logic cur_write_reg; // Current access is a write.
  logic cur_table_reg; // Current access is a table operation.
  logic [ADDR_W-1:0] addr_reg; // Address of the current access.
  logic [7:0] tdata_reg; // Latched table data.
  logic done_reg; // Completion pulse.
  logic [15:0] rdata_reg; // Captured read data.
  logic [1:0] rd_pipe_reg; // Read data still on its way through the two input flops.
  // Derived signals.
  logic internal_only; // Mode with no external bus.
  logic bus_disable; // External bus disable bit.
  logic [ADDR_W-1:0] shifted_addr; // Address after optional shift.
  logic own_low; // Bus owns AD7:AD0.
  logic [7:0] own_mid; // Bus owns AD15:AD8.
  logic own_high; // Bus owns A19:A16.
  logic wide_addr_ok; // 21-bit addressing allowed.
  logic byte_write_mode; // 16-bit byte write.
  logic byte_select_mode; // 16-bit byte select.
  logic word_write_mode; // 16-bit word write.
  logic [1:0] wait_count; // Decoded delay.
  logic access_end; // Last data or wait cycle of an access.

  assign internal_only = (address_width_select_in == AW_INTERNAL);
  assign bus_disable = bcr_reg[BCR_DIS_POS];
  assign wait_count = wait_cycles(bcr_reg[BCR_WAIT_POS +: 2]);
  assign access_end = (phase_reg == ST_DATA && !(delay_insert_enable_in && cur_table_reg
                      && wait_count != 2'h0)) || (phase_reg == ST_WAIT && wait_reg == 2'h0);
  // Write mode decode.
  assign word_write_mode = bcr_reg[BCR_WM_POS + 1];
  assign byte_select_mode = (bcr_reg[BCR_WM_POS +: 2] == WM_BYTE_SELECT);
  assign byte_write_mode = (bcr_reg[BCR_WM_POS +: 2] == WM_BYTE_WRITE);
  // Byte address only in 8-bit width or 16-bit byte select.
  assign wide_addr_ok = !data_width_16_in || byte_select_mode;

  // Address translation.
  ext_bus_addr_map u_addr_map (
    .pc_in(program_counter_in),
    .shift_in(address_shift_enable_in),
    .onchip_size_in(ONCHIP_SIZE),
    .bus_addr_out(shifted_addr)
  );

  // Pin ownership by address width.
  ext_bus_pin_owner u_pin_owner (
    .address_width_select_in(address_width_select_in),
    .bus_active_in(pins_bus_reg),
    .own_low_out(own_low),
    .own_mid_out(own_mid),
    .own_high_out(own_high)
  );

  // Bus control register, locked in internal-only mode.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      bcr_reg <= BCR_RESET;
    end else if (bcr_write_in && !internal_only) begin
      bcr_reg <= bcr_wdata_in & BCR_MASK;
    end
  end

  // Pull-up enables from port G top bits, cleared on reset.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      pullup_reg <= PU_RESET;
    end else if (port_g_write_in) begin
      pullup_reg <= {port_g_wdata_in[PU_D_POS], port_g_wdata_in[PU_E_POS],
                     port_g_wdata_in[PU_J_POS]};
    end
  end

  // Input data pins pass two flip-flops before use.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ad_sync1_reg <= 16'h0000;
      ad_sync2_reg <= 16'h0000;
    end else begin
      ad_sync1_reg <= ad_pin_in;
      ad_sync2_reg <= ad_sync1_reg;
    end
  end

  // Track whether execution is in external memory for the deferred disable.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ext_exec_reg <= 1'b0;
    end else if (access_req_in && !access_write_in) begin
      ext_exec_reg <= access_external_in && !internal_only;
    end
  end

  // Pin function: bus or ports.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      pins_bus_reg <= 1'b0;
    end else if (internal_only) begin
      pins_bus_reg <= 1'b0;
    end else if (access_req_in && access_external_in) begin
      pins_bus_reg <= 1'b1;
    end else if (ext_exec_reg) begin
      pins_bus_reg <= pins_bus_reg;
    end else begin
      pins_bus_reg <= !bus_disable;
    end
  end

  // Bus cycle sequencer: address latch, data phase, then waits.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      phase_reg <= ST_IDLE;
      wait_reg <= 2'h0;
      cur_write_reg <= 1'b0;
      cur_table_reg <= 1'b0;
      addr_reg <= '0;
      tdata_reg <= 8'h00;
    end else begin
      case (phase_reg)
        ST_IDLE: begin
          if (access_req_in && access_external_in && !internal_only && !sleep_in) begin
            phase_reg <= ST_ADDR;
            cur_write_reg <= access_write_in;
            cur_table_reg <= access_write_in || (program_counter_in[0] == 1'b0);
            addr_reg <= shifted_addr;
            tdata_reg <= table_data_latch_in;
          end
        end
        ST_ADDR: begin
          phase_reg <= ST_DATA;
        end
        ST_DATA: begin
          if (delay_insert_enable_in && cur_table_reg && wait_count != 2'h0) begin
            phase_reg <= ST_WAIT;
            wait_reg <= wait_count - 2'h1;
          end else begin
            phase_reg <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          if (wait_reg == 2'h0) begin
            phase_reg <= ST_IDLE;
          end else begin
            wait_reg <= wait_reg - 2'h1;
          end
        end
        default: begin
          phase_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Completion pulse and read capture; a read ends once its data has left both input flops.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      done_reg <= 1'b0;
      rd_pipe_reg <= 2'h0;
      rdata_reg <= 16'h0000;
    end else begin
      done_reg <= (access_end && cur_write_reg) || rd_pipe_reg[1];
      rd_pipe_reg <= {rd_pipe_reg[0], access_end && !cur_write_reg};
      if (rd_pipe_reg[1]) begin
        rdata_reg <= data_width_16_in ? ad_sync2_reg : {8'h00, ad_sync2_reg[7:0]};
      end
    end
  end

  // Pin drive: address phase, data phase, idle state.
  always_comb begin
    ad_out = 16'h0000;
    ad_oe_n_out = 16'hFFFF;
    a_high_out = addr_reg[20:17];
    a_high_oe_n_out = {4{!own_high}};
    latch_strobe_out = 1'b0;
    read_enable_n_out = 1'b1;
    lower_write_strobe_n_out = 1'b1;
    upper_write_strobe_n_out = 1'b1;
    byte_address_lsb_out = 1'b0;
    chip_select_n_out = 1'b1;
    lower_byte_enable_n_out = 1'b1;
    upper_byte_enable_n_out = 1'b1;
    if (phase_reg == ST_ADDR) begin
      // Word address on all owned lines; the byte address line stays low until the data phase.
      ad_out = addr_reg[16:1];
      ad_oe_n_out = {~own_mid, {8{!own_low}}};
      latch_strobe_out = 1'b1;
      chip_select_n_out = 1'b0;
    end else if (phase_reg == ST_DATA || phase_reg == ST_WAIT) begin
      chip_select_n_out = 1'b0;
      byte_address_lsb_out = wide_addr_ok && addr_reg[0];
      ad_out = addr_reg[16:1];
      ad_oe_n_out = data_width_16_in ? 16'hFFFF : {~own_mid, 8'hFF};
      if (cur_write_reg) begin
        ad_out = {tdata_reg, tdata_reg};
        ad_oe_n_out = {~own_mid, {8{!own_low}}};
        if (!data_width_16_in || byte_write_mode) begin
          lower_write_strobe_n_out = addr_reg[0];
          upper_write_strobe_n_out = !addr_reg[0];
        end else if (byte_select_mode) begin
          upper_write_strobe_n_out = 1'b0;
          upper_byte_enable_n_out = !addr_reg[0];
          lower_byte_enable_n_out = addr_reg[0];
        end else if (word_write_mode) begin
          upper_write_strobe_n_out = !addr_reg[0];
          upper_byte_enable_n_out = 1'b0;
          lower_byte_enable_n_out = 1'b0;
        end
      end else begin
        read_enable_n_out = 1'b0;
        upper_byte_enable_n_out = 1'b0;
        lower_byte_enable_n_out = 1'b0;
      end
    end
    if (sleep_in) begin
      chip_select_n_out = 1'b1;
      lower_byte_enable_n_out = 1'b1;
      upper_byte_enable_n_out = 1'b1;
    end
  end

  // Control pins driven by the bus whenever it owns the pins.
  assign control_oe_n_out = !own_low;
  assign bus_owns_pins_out = own_low;
  assign access_done_out = done_reg;
  assign read_data_out = rdata_reg;
  assign bus_control_register_out = bcr_reg;
  assign port_d_pullup_enable_out = pullup_reg[2];
  assign port_e_pullup_enable_out = pullup_reg[1];
  assign port_j_pullup_enable_out = pullup_reg[0];

  // Checks.
  property p_internal_lock;
    @(posedge mclk_in) disable iff (reset_in)
      internal_only |=> $stable(bcr_reg) && !pins_bus_reg;
  endproperty
  a_internal_lock: assert property (p_internal_lock) else $error("register changed");
  property p_ext_takes_pins;
    @(posedge mclk_in) disable iff (reset_in)
      (access_req_in && access_external_in && !internal_only) |=> pins_bus_reg;
  endproperty
  a_ext_takes_pins: assert property (p_ext_takes_pins) else $error("bus not taken");
  property p_latch_then_read;
    @(posedge mclk_in) disable iff (reset_in)
      (latch_strobe_out && !cur_write_reg && !sleep_in) |=> !read_enable_n_out;
  endproperty
  a_latch_then_read: assert property (p_latch_then_read) else $error("no read");
  property p_one_strobe;
    @(posedge mclk_in) disable iff (reset_in)
      !(lower_write_strobe_n_out == 1'b0 && upper_write_strobe_n_out == 1'b0);
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("both write strobes low");
  property p_sleep_cs;
    @(posedge mclk_in) disable iff (reset_in)
      sleep_in |-> chip_select_n_out;
  endproperty
  a_sleep_cs: assert property (p_sleep_cs) else $error("chip select low in sleep");
  property p_wait_len;
    @(posedge mclk_in) disable iff (reset_in)
      (phase_reg == ST_DATA && cur_table_reg && delay_insert_enable_in
       && bcr_reg[5:4] == 2'h0) |=> (phase_reg == ST_WAIT) [*3] ##1 (phase_reg == ST_IDLE);
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("wrong wait length");
  property p_idle_pins;
    @(posedge mclk_in) disable iff (reset_in)
      (phase_reg == ST_IDLE) |-> ad_oe_n_out == 16'hFFFF && !latch_strobe_out
        && read_enable_n_out && !byte_address_lsb_out;
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("idle bus not idle");
  property p_no_high_at16;
    @(posedge mclk_in) disable iff (reset_in)
      (address_width_select_in != AW_20) |-> a_high_oe_n_out == 4'hF;
  endproperty
  a_no_high_at16: assert property (p_no_high_at16) else $error("upper lines driven");
endmodule

// ==== dv/ext_mem_model.sv ====
// Behavioural external word-wide memory that answers the bus pins.
module ext_mem_model (
  // Clock.
  input wire logic mclk_in,
  // Bus pins from the port.
  input wire logic [15:0] ad_in,
  input wire logic [15:0] ad_oe_n_in,
  input wire logic [3:0] a_high_in,
  input wire logic latch_in,
  input wire logic read_n_in,
  input wire logic cs_n_in,
  input wire logic lo_wr_n_in,
  input wire logic hi_wr_n_in,
  input wire logic ba0_in,
  // Resolved pin level and observations.
  output logic [15:0] ad_pin_out,
  output logic [20:0] addr_out,
  output logic [15:0] wdata_out,
  output int wr_lo_cnt_out,
  output int wr_hi_cnt_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] drv; // What the memory puts on the lines.
  logic [15:0] last_q = 16'h0000; // Last value, inverted once released.
  // The memory drives read data while selected and read enabled, else the inverted last value.
  always_comb begin
    if (!cs_n_in && !read_n_in) begin
      drv = addr_out[16:1] ^ 16'h5A3C;
    end else begin
      drv = ~last_q;
    end
  end
  // Wire level: the port wins on every bit it enables.
  assign ad_pin_out = (ad_in & ~ad_oe_n_in) | (drv & ad_oe_n_in);
  initial begin
    addr_out = 21'h000000;
    wdata_out = 16'h0000;
    wr_lo_cnt_out = 0;
    wr_hi_cnt_out = 0;
  end
  // Latch the address and count write strobes.
  always @(posedge mclk_in) begin
    last_q <= drv;
    if (latch_in) begin
      addr_out <= {a_high_in, ad_in, ba0_in};
    end
    if (!lo_wr_n_in) begin
      wr_lo_cnt_out <= wr_lo_cnt_out + 1;
      wdata_out <= ad_in;
    end
    if (!hi_wr_n_in) begin
      wr_hi_cnt_out <= wr_hi_cnt_out + 1;
      wdata_out <= ad_in;
    end
  end
endmodule

// ==== dv/ext_bus_port_test.sv ====
// Self-checking bench for the external memory bus port.
module ext_bus_port_test;
  import ext_bus_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [20:0] ONCHIP = 21'h004000; // Small on-chip size.
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [1:0] address_width_select_in = AW_20;
  logic data_width_16_in = 1'b1;
  logic address_shift_enable_in = 1'b0;
  logic delay_insert_enable_in = 1'b1;
  logic sleep_in = 1'b0;
  logic bcr_write_in = 1'b0;
  logic [7:0] bcr_wdata_in = 8'h00;
  logic port_g_write_in = 1'b0;
  logic [7:0] port_g_wdata_in = 8'h00;
  logic access_req_in = 1'b0;
  logic access_write_in = 1'b0;
  logic access_external_in = 1'b0;
  logic [20:0] program_counter_in = 21'h000000;
  logic [7:0] table_data_latch_in = 8'h00;
  logic access_done_out, latch_strobe_out, read_enable_n_out, chip_select_n_out;
  logic [15:0] read_data_out, ad_pin_in, ad_out, ad_oe_n_out, wdata;
  logic [7:0] bus_control_register_out;
  logic [3:0] a_high_out, a_high_oe_n_out;
  logic lower_write_strobe_n_out, upper_write_strobe_n_out, byte_address_lsb_out;
  logic lower_byte_enable_n_out, upper_byte_enable_n_out, bus_owns_pins_out;
  logic port_d_pullup_enable_out, port_e_pullup_enable_out, port_j_pullup_enable_out;
  logic [20:0] mem_addr;
  int wr_lo, wr_hi, error_cnt = 0, samples_checked = 0;
  // Clock at 40 MHz.
  always #12.5 mclk_in = ~mclk_in;
  ext_bus_port #(.ONCHIP_SIZE(ONCHIP)) i_dut (.*, .control_oe_n_out());
  ext_mem_model i_mem (.mclk_in(mclk_in), .ad_in(ad_out), .ad_oe_n_in(ad_oe_n_out),
    .a_high_in(a_high_out), .latch_in(latch_strobe_out), .read_n_in(read_enable_n_out),
    .cs_n_in(chip_select_n_out), .lo_wr_n_in(lower_write_strobe_n_out),
    .hi_wr_n_in(upper_write_strobe_n_out), .ba0_in(byte_address_lsb_out),
    .ad_pin_out(ad_pin_in), .addr_out(mem_addr), .wdata_out(wdata),
    .wr_lo_cnt_out(wr_lo), .wr_hi_cnt_out(wr_hi));
  // Prints the verdict and stops.
  task automatic close_out();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds reset for twelve cycles.
  task automatic do_reset();
    reset_in = 1'b1;
    repeat (12) @(negedge mclk_in);
    reset_in = 1'b0;
  endtask
  // Writes the bus control register or the port G register.
  task automatic reg_wr(input logic g, input logic [7:0] v);
    @(negedge mclk_in);
    bcr_write_in = !g;
    bcr_wdata_in = v;
    port_g_write_in = g;
    port_g_wdata_in = v;
    @(negedge mclk_in);
    bcr_write_in = 1'b0;
    port_g_write_in = 1'b0;
  endtask
  // Presents one request for a single cycle.
  task automatic pulse_req(input logic wr, input logic ext, input logic [20:0] pc,
                           input logic [7:0] tdl);
    @(negedge mclk_in);
    access_req_in = 1'b1;
    access_write_in = wr;
    access_external_in = ext;
    program_counter_in = pc;
    table_data_latch_in = tdl;
    @(negedge mclk_in);
    access_req_in = 1'b0;
  endtask
  // Full external access; returns latency and upper address enables.
  task automatic access(input logic wr, input logic [20:0] pc, input logic [7:0] tdl,
                        output int lat, output logic [3:0] hoe);
    int n;
    hoe = 4'hF;
    pulse_req(wr, 1'b1, pc, tdl);
    n = 1;
    while (access_done_out !== 1'b1 && n < 12) begin
      if (latch_strobe_out === 1'b1) begin
        hoe = a_high_oe_n_out;
      end
      @(negedge mclk_in);
      n++;
    end
    lat = n;
    if (n >= 12) begin
      error_cnt++;
      close_out();
    end
  endtask
  // Idle pin levels seen by the memory.
  function automatic logic [23:0] idle_pins();
    return {chip_select_n_out, read_enable_n_out, lower_write_strobe_n_out,
            upper_write_strobe_n_out, upper_byte_enable_n_out, lower_byte_enable_n_out,
            latch_strobe_out, byte_address_lsb_out, ad_oe_n_out};
  endfunction
  initial begin
    int lat, lo0, hi0;
    logic [3:0] hoe;
    logic [20:0] pc;
    logic [7:0] d;
    void'($urandom(32'h5db90b23));
    do_reset();
    chk({port_d_pullup_enable_out, port_e_pullup_enable_out, port_j_pullup_enable_out},
        0);
    chk(idle_pins(), 24'hFCFFFF);
    // Every delay field value, reads in byte select mode.
    for (int f = 0; f < 4; f++) begin
      reg_wr(1'b0, {2'h0, f[1:0], 4'h1});
      chk(bus_control_register_out, {2'h0, f[1:0], 4'h1});
      pc = 21'($urandom) & 21'h1FFFFE;
      access(1'b0, pc, 8'h00, lat, hoe);
      chk(lat, 5 + (3 - f));
      chk(mem_addr, pc);
      chk(read_data_out, pc[16:1] ^ 16'h5A3C);
      chk(hoe, 4'h0);
      chk(idle_pins(), 24'hFCFFFF);
    end
    // No waits when delay insertion is off; shifted address.
    delay_insert_enable_in = 1'b0;
    address_shift_enable_in = 1'b1;
    pc = ONCHIP + (21'($urandom) & 21'h00FFFE);
    access(1'b0, pc, 8'h00, lat, hoe);
    chk(lat, 5);
    chk(mem_addr, pc - ONCHIP);
    address_shift_enable_in = 1'b0;
    // Writes in every write mode with both pointer parities.
    for (int m = 0; m < 4; m++) begin
      reg_wr(1'b0, {6'h30, m[1:0]});
      for (int b = 0; b < 2; b++) begin
        d = 8'($urandom);
        lo0 = wr_lo;
        hi0 = wr_hi;
        access(1'b1, {20'($urandom), b[0]}, d, lat, hoe);
        chk(wr_lo - lo0, (m == 0 && b == 0) ? 1 : 0);
        chk(wr_hi - hi0, (m == 0) ? b : (m == 1) ? 1 : b);
        if (m < 2 && (wr_lo - lo0 + wr_hi - hi0) == 1) begin
          chk(wdata, {d, d});
        end
      end
    end
    // Pull-ups follow port G and clear on reset.
    d = 8'($urandom) | 8'h20;
    reg_wr(1'b1, d);
    @(negedge mclk_in);
    chk({port_d_pullup_enable_out, port_e_pullup_enable_out, port_j_pullup_enable_out},
        d[7:5]);
    do_reset();
    chk(port_d_pullup_enable_out | port_e_pullup_enable_out | port_j_pullup_enable_out,
        0);
    // Disable bit: ports on internal access, bus on external access.
    reg_wr(1'b0, 8'hB1);
    pulse_req(1'b0, 1'b0, 21'h000100, 8'h00);
    repeat (3) @(negedge mclk_in);
    chk(bus_owns_pins_out, 0);
    access(1'b0, 21'h010000, 8'h00, lat, hoe);
    chk(bus_owns_pins_out, 1);
    pulse_req(1'b0, 1'b0, 21'h000100, 8'h00);
    repeat (3) @(negedge mclk_in);
    chk(bus_owns_pins_out, 0);
    reg_wr(1'b0, 8'h31);
    pulse_req(1'b0, 1'b0, 21'h000100, 8'h00);
    repeat (3) @(negedge mclk_in);
    chk(bus_owns_pins_out, 1);
    // At 16-bit address width the top lines stay ports.
    address_width_select_in = AW_16;
    do_reset();
    access(1'b0, 21'h000200, 8'h00, lat, hoe);
    chk(hoe, 4'hF);
    // Internal-only mode ignores register writes and keeps the bus off.
    address_width_select_in = AW_INTERNAL;
    do_reset();
    reg_wr(1'b0, 8'h31);
    pulse_req(1'b0, 1'b1, 21'h010000, 8'h00);
    chk({bus_control_register_out, bus_owns_pins_out, chip_select_n_out}, 10'h001);
    // Chip select is low in an access, and sleep forces it high even in mid-access.
    address_width_select_in = AW_20;
    do_reset();
    pulse_req(1'b0, 1'b1, 21'h000400, 8'h00);
    chk(chip_select_n_out, 0);
    sleep_in = 1'b1;
    #1;
    chk({chip_select_n_out, upper_byte_enable_n_out, lower_byte_enable_n_out},
        3'h7);
    close_out();
  end
endmodule
